// ==== bench/ics_prog_memory.sv ====
// Purpose: Program memory model for the sequencer bench.
// Assumes: Byte index equals the count of bytes already fetched.
// Notes: Combinational read; the bench preloads mem.
`timescale 1ns/1ps
module ics_prog_memory (
  input wire logic [15:0] addr_i, // Next program byte index
  output logic [7:0] data_o // Program byte
);
  logic [7:0] mem [0:255];
  // Wraps at 256 bytes, plenty for the short programs used
  assign data_o = mem[addr_i[7:0]];
endmodule : ics_prog_memory

// ==== bench/ics_sequencer_assertions.sv ====
// Purpose: Port-level checks on the instruction cycle sequencer.
// Assumes: Speed mode is held for many clocks between changes.
// Notes: Length checks wait 8 clocks after a mode change.
`timescale 1ns/1ps
module ics_sequencer_assertions (
  input wire logic clock_i, // Core clock
  input wire logic srst_i, // Sync reset
  input wire logic [1:0] speed_i, // Speed mode
  input wire logic prog_fetch_o, // Program fetch
  input wire logic xdata_write_o, // External write
  input wire logic opcode_fetch_o, // Opcode fetch
  input wire logic [7:0] opcode_o, // Opcode
  input wire logic [2:0] cycle_idx_o, // Cycle index
  input wire logic cycle_end_o, // Cycle end pulse
  input wire logic instr_done_o, // Done pulse
  input wire logic [1:0] clock_state_slot_o, // State slot
  input wire logic [15:0] fetch_count_o // Fetch count
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  cycle_len_a: assert property (
    cycle_end_o && speed_i == 2'b00 && $past(speed_i, 8) == 2'b00
    |=> !cycle_end_o [*3] ##1 cycle_end_o) else $error("normal cycle not four clocks");
  slow_len_a: assert property (
    cycle_end_o && speed_i == 2'b01 && $past(speed_i, 8) == 2'b01
    |=> ##63 cycle_end_o) else $error("slow cycle not 64 clocks");
  end_pulse_a: assert property (
    cycle_end_o |=> !cycle_end_o) else $error("cycle end wider than one clock");
  slot_step_a: assert property (
    $changed(clock_state_slot_o) |-> clock_state_slot_o == $past(clock_state_slot_o) + 2'h1)
    else $error("state slot skipped");
  next_fetch_a: assert property (
    instr_done_o && opcode_o != 8'hF0 && speed_i == 2'b00 && $past(speed_i, 8) == 2'b00
    |-> cycle_end_o ##4 (cycle_end_o && opcode_fetch_o)) else $error("no fetch after done");
  ext_write_a: assert property (
    xdata_write_o |-> opcode_o == 8'hF0 && !prog_fetch_o && !opcode_fetch_o)
    else $error("bad external write");
  op_fetch_a: assert property (
    opcode_fetch_o |-> prog_fetch_o) else $error("opcode without fetch");
  five_only_a: assert property (
    cycle_idx_o == 3'h4 && opcode_o != 8'hF0 |-> opcode_o == 8'hA4 || opcode_o == 8'h84)
    else $error("fifth cycle on wrong opcode");
  count_step_a: assert property (
    $changed(fetch_count_o) |-> fetch_count_o == $past(fetch_count_o) + 16'h0001 && prog_fetch_o)
    else $error("fetch count step wrong");
endmodule : ics_sequencer_assertions
bind ics_sequencer ics_sequencer_assertions chk_u (.clock_i, .srst_i, .speed_i, .prog_fetch_o,
  .xdata_write_o, .opcode_fetch_o, .opcode_o, .cycle_idx_o, .cycle_end_o, .instr_done_o,
  .clock_state_slot_o, .fetch_count_o);

// ==== bench/ics_sequencer_test.sv ====
// Purpose: Self-checking bench for the instruction cycle sequencer.
// Assumes: Memory model answers from the fetch count.
// Notes: Each instruction is timed from one opcode fetch to the next.
`timescale 1ns/1ps
module ics_sequencer_test;
  typedef struct packed {logic [7:0] op; logic [3:0] nb; logic [3:0] cyc;} ics_row_s;
  logic clock_i, srst_i, branch_take_i, prog_fetch_o, xdata_write_o, opcode_fetch_o;
  logic cycle_end_o, instr_done_o;
  logic [1:0] speed_i, clock_state_slot_o;
  logic [2:0] stretch_i, cycle_idx_o;
  logic [7:0] prog_data_i, opcode_o;
  logic [15:0] fetch_count_o, ncyc, nfet, nwr, nclk, exp_clk, ndone;
  ics_row_s tab [0:12];
  int errors, num_checks, k, n, skip, tick;
  ics_sequencer DUT (.clock_i, .srst_i, .speed_i, .stretch_i, .prog_data_i, .branch_take_i,
    .prog_fetch_o, .xdata_write_o, .opcode_fetch_o, .opcode_o, .cycle_idx_o, .cycle_end_o,
    .instr_done_o, .clock_state_slot_o, .fetch_count_o);
  ics_prog_memory prog (.addr_i(fetch_count_o), .data_o(prog_data_i));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  task automatic run_prog(input int cnt, input string name);
    int a;
    a = 0;
    for (int i = 0; i < 256; i++) prog.mem[i] = 8'h14;
    for (int i = 0; i < cnt; i++) begin
      prog.mem[a] = tab[i].op;
      a += int'(tab[i].nb);
    end
    n = cnt;
    @(posedge clock_i);
    #1 srst_i = 1'b1;
    repeat (6) @(posedge clock_i);
    #1 srst_i = 1'b0;
    chk({clock_state_slot_o, prog_fetch_o, cycle_end_o, instr_done_o, fetch_count_o}, 0);
    k = 0;
    skip = 1;
    wait (k > n);
    @(posedge clock_i);
    #1 $display("test %s done", name);
  endtask : run_prog
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Sampling on the falling edge keeps clear of the registered outputs
  always @(negedge clock_i) begin
    tick++;
    nclk++;
    if (tick > 20000) begin
      errors++;
      end_of_test();
    end
    if (!srst_i && cycle_end_o) begin
      if (skip > 0) skip--;
      else chk(nclk, exp_clk);
      chk(clock_state_slot_o, 32'h3);
      nclk = 0;
      if (opcode_fetch_o) begin
        if (k > 0 && k <= n) begin
          chk(ncyc, tab[k-1].cyc);
          chk(nfet, tab[k-1].nb);
          chk(nwr, tab[k-1].op == 8'hF0);
          chk(ndone, 32'h1);
        end
        if (k < n) chk(opcode_o, tab[k].op);
        k++;
        ncyc = 0;
        nfet = 0;
        nwr = 0;
        ndone = 0;
      end
      if (stretch_i == 3'h0) chk(cycle_idx_o, ncyc);
      ncyc++;
      nfet += prog_fetch_o;
      nwr += xdata_write_o;
      ndone += instr_done_o;
    end
  end
  initial begin
    srst_i = 1'b1;
    {branch_take_i, speed_i, stretch_i} = 0;
    {errors, num_checks, k, n, skip, tick} = 0;
    {ncyc, nfet, nwr, nclk, ndone} = 0;
    exp_clk = 16'h0004;
    tab = '{'{8'h14, 4'h1, 4'h1}, '{8'h04, 4'h1, 4'h1}, '{8'h55, 4'h2, 4'h2},
      '{8'h54, 4'h2, 4'h2}, '{8'h52, 4'h2, 4'h2}, '{8'hF0, 4'h1, 4'h2}, '{8'h53, 4'h3, 4'h3},
      '{8'h80, 4'h2, 4'h3}, '{8'hA3, 4'h1, 4'h3}, '{8'h22, 4'h1, 4'h4}, '{8'hB4, 4'h3, 4'h4},
      '{8'hA4, 4'h1, 4'h5}, '{8'h84, 4'h1, 4'h5}};
    run_prog(13, "table");
    // Stretched write then a plain opcode, after a mid-run reset
    tab[0] = '{8'hF0, 4'h1, 4'h4};
    tab[1] = '{8'h14, 4'h1, 4'h1};
    stretch_i = 3'h2;
    branch_take_i = 1'b1;
    run_prog(2, "stretch");
    stretch_i = 3'h0;
    speed_i = 2'b01;
    skip = 2;
    exp_clk = 16'h0040;
    repeat (320) @(posedge clock_i);
    #1 speed_i = 2'b10;
    skip = 2;
    exp_clk = 16'h0400;
    repeat (4096) @(posedge clock_i);
    #1 speed_i = 2'b00;
    skip = 2;
    exp_clk = 16'h0004;
    // A slow-two cycle in progress must finish before normal cycles show
    repeat (2100) @(posedge clock_i);
    $display("test speed done");
    end_of_test();
  end
endmodule : ics_sequencer_test

// ==== logic/ics_cycle_decoder.sv ====
// Purpose: Maps an opcode to machine-cycle count and per-cycle access.
// Assumes: Opcodes outside the listed groups are single cycle.
// Notes: Pure combinational; the sequencer registers its results.
`timescale 1ns/1ps
module ics_cycle_decoder (
  input wire logic [7:0] opcode_i, // Fetched opcode
  output logic [2:0] cycles_o, // Machine cycles, 1..5
  output logic [2:0] bytes_o, // Instruction length in bytes
  output logic ext_write_o, // Second cycle writes external data
  output logic branch_o // Instruction may change fetch address
);
  always_comb begin
    cycles_o = 3'h1;
    bytes_o = 3'h1;
    ext_write_o = 1'b0;
    branch_o = 1'b0;
    unique case (opcode_i)
      ics_pkg::OP_AND_ACC_DIRECT, ics_pkg::OP_AND_ACC_IMM,
      ics_pkg::OP_AND_DIRECT_ACC: begin
        cycles_o = 3'h2;
        bytes_o = 3'h2;
      end
      ics_pkg::OP_EXT_WRITE_PTR: begin
        cycles_o = 3'h2;
        ext_write_o = 1'b1;
      end
      ics_pkg::OP_AND_DIRECT_IMM: begin
        cycles_o = 3'h3;
        bytes_o = 3'h3;
      end
      ics_pkg::OP_SHORT_JUMP: begin
        cycles_o = 3'h3;
        bytes_o = 3'h2;
        branch_o = 1'b1;
      end
      ics_pkg::OP_POINTER_STEP_UP: cycles_o = 3'h3;
      ics_pkg::OP_CALL_EXIT: begin
        cycles_o = 3'h4;
        branch_o = 1'b1;
      end
      ics_pkg::OP_COMPARE_BRANCH: begin
        cycles_o = 3'h4;
        bytes_o = 3'h3;
        branch_o = 1'b1;
      end
      ics_pkg::OP_PRODUCT, ics_pkg::OP_QUOTIENT: cycles_o = 3'h5;
      default: cycles_o = 3'h1;
    endcase
  end
endmodule : ics_cycle_decoder

// ==== logic/ics_pkg.sv ====
// Purpose: Constants for the instruction cycle sequencer.
// Assumes: 8-bit opcodes, one core clock at 100 MHz.
// Notes: Cycle counts per opcode live in the decoder module.
package ics_pkg;
  localparam logic [10:0] CLK_PER_CYC_NORMAL = 11'h004;
  localparam logic [10:0] CLK_PER_CYC_SLOW1 = 11'h040;
  localparam logic [10:0] CLK_PER_CYC_SLOW2 = 11'h400;
  localparam logic [7:0] OP_ACC_MINUS_ONE = 8'h14;
  localparam logic [7:0] OP_AND_ACC_DIRECT = 8'h55;
  localparam logic [7:0] OP_AND_ACC_IMM = 8'h54;
  localparam logic [7:0] OP_AND_DIRECT_ACC = 8'h52;
  localparam logic [7:0] OP_AND_DIRECT_IMM = 8'h53;
  localparam logic [7:0] OP_EXT_WRITE_PTR = 8'hF0;
  localparam logic [7:0] OP_SHORT_JUMP = 8'h80;
  localparam logic [7:0] OP_POINTER_STEP_UP = 8'hA3;
  localparam logic [7:0] OP_CALL_EXIT = 8'h22;
  localparam logic [7:0] OP_COMPARE_BRANCH = 8'hB4;
  localparam logic [7:0] OP_PRODUCT = 8'hA4;
  localparam logic [7:0] OP_QUOTIENT = 8'h84;
  localparam logic [2:0] STRETCH_MAX = 3'h7;
  typedef enum logic [1:0] {
    ICS_SPEED_NORMAL = 2'b00,
    ICS_SPEED_SLOW1 = 2'b01,
    ICS_SPEED_SLOW2 = 2'b10
  } ics_speed_e;
  typedef enum logic [1:0] {
    ICS_ACC_NONE = 2'b00,
    ICS_ACC_FETCH = 2'b01,
    ICS_ACC_XWRITE = 2'b10
  } ics_access_e;
endpackage : ics_pkg

// ==== logic/ics_sequencer.sv ====
// Purpose: Instruction cycle sequencer for a four-clock machine cycle core.
// Assumes: Program memory returns a byte in the same machine cycle it is asked.
// Notes: Stretch cycles add idle machine cycles after an external write.
//
// Behaviour
// - Machine cycle is four clocks normally.
// - Single-byte simple opcodes finish in one cycle.
// - And-accumulator-direct takes two fetch cycles.
// - And-accumulator-immediate takes two fetch cycles.
// - External pointer write takes two cycles.
// - Software stretch lengthens external move cycles.
// - And-direct-immediate takes three fetch cycles.
// - Short relative jump takes three cycles.
// - Pointer step up takes three cycles.
// - Call exit, compare branch take four cycles.
// - Product and quotient take five cycles.
// - Four states in every machine cycle.
// - Slow modes use 64 or 1024 clocks.
`timescale 1ns/1ps
module ics_sequencer (
  input wire logic clock_i, // Core clock, 100 MHz
  input wire logic srst_i, // Sync reset, active high
  input wire logic [1:0] speed_i, // Speed mode select
  input wire logic [2:0] stretch_i, // Extra cycles for external moves
  input wire logic [7:0] prog_data_i, // Byte read from program memory
  input wire logic branch_take_i, // Datapath: branch changes fetch address
  output logic prog_fetch_o, // Program byte fetched this cycle
  output logic xdata_write_o, // External data write this cycle
  output logic opcode_fetch_o, // Fetched byte is an opcode
  output logic [7:0] opcode_o, // Opcode being executed
  output logic [2:0] cycle_idx_o, // Machine cycle within instruction
  output logic cycle_end_o, // Pulse: machine cycle ends
  output logic instr_done_o, // Pulse: instruction ends
  output logic [1:0] clock_state_slot_o, // State within machine cycle
  output logic [15:0] fetch_count_o // Program bytes fetched
);
  logic cend;
  logic [1:0] slot;
  logic [2:0] dec_cycles;
  logic [2:0] dec_bytes;
  logic dec_xw;
  logic dec_br;
  logic [2:0] ncyc_q;
  logic [2:0] nbyt_q;
  logic xw_q;
  logic [2:0] idx_q;
  logic [2:0] str_q;
  logic [7:0] op_q;
  logic wr_pend_q;
  logic [1:0] speed_q;
  logic [2:0] stretch_q;
  logic [2:0] cur_cycles;
  logic [2:0] cur_bytes;
  logic cur_xw;
  logic last_cycle;

  ics_state_divider u_div (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .speed_i(speed_q),
    .state_adv_o(),
    .cycle_end_o(cend),
    .slot_o(slot)
  );

  ics_cycle_decoder u_dec (
    .opcode_i(idx_q == 3'h0 ? prog_data_i : op_q),
    .cycles_o(dec_cycles),
    .bytes_o(dec_bytes),
    .ext_write_o(dec_xw),
    .branch_o(dec_br)
  );

  // Mode and stretch come from other core logic on this clock
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      speed_q <= ics_pkg::ICS_SPEED_NORMAL;
      stretch_q <= 3'h0;
    end else begin
      speed_q <= speed_i;
      stretch_q <= stretch_i;
    end
  end

  assign cur_cycles = idx_q == 3'h0 ? dec_cycles : ncyc_q;
  assign cur_bytes = idx_q == 3'h0 ? dec_bytes : nbyt_q;
  assign cur_xw = idx_q == 3'h0 ? dec_xw : xw_q;
  // Stretch cycles hold the write phase before the instruction can finish
  assign last_cycle = (idx_q + 3'h1 >= cur_cycles) && (str_q == 3'h0);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      idx_q <= 3'h0;
      op_q <= 8'h00;
      ncyc_q <= 3'h1;
      nbyt_q <= 3'h1;
      xw_q <= 1'b0;
      str_q <= 3'h0;
      wr_pend_q <= 1'b0;
    end else if (cend) begin
      // Only the cycle right after the opcode writes; stretch cycles stay idle
      wr_pend_q <= cur_xw && idx_q == 3'h0;
      if (idx_q == 3'h0) begin
        op_q <= prog_data_i;
        ncyc_q <= dec_cycles;
        nbyt_q <= dec_bytes;
        xw_q <= dec_xw;
      end
      if (str_q != 3'h0) begin
        str_q <= str_q - 3'h1;
      end else if (last_cycle) begin
        idx_q <= 3'h0;
      end else begin
        idx_q <= idx_q + 3'h1;
        if (cur_xw && idx_q == 3'h0) begin
          str_q <= stretch_q;
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      prog_fetch_o <= 1'b0;
      xdata_write_o <= 1'b0;
      opcode_fetch_o <= 1'b0;
      opcode_o <= 8'h00;
      cycle_idx_o <= 3'h0;
      cycle_end_o <= 1'b0;
      instr_done_o <= 1'b0;
      clock_state_slot_o <= 2'b00;
      fetch_count_o <= 16'h0000;
    end else begin
      cycle_end_o <= cend;
      instr_done_o <= cend && last_cycle;
      clock_state_slot_o <= slot;
      if (cend) begin
        cycle_idx_o <= idx_q;
        opcode_o <= idx_q == 3'h0 ? prog_data_i : op_q;
        // Fetch only while the instruction still has bytes left
        prog_fetch_o <= idx_q < cur_bytes;
        opcode_fetch_o <= idx_q == 3'h0;
        xdata_write_o <= wr_pend_q;
        if (idx_q < cur_bytes) begin
          fetch_count_o <= fetch_count_o + 16'h0001;
        end
      end
    end
  end

  logic unused_br;
  assign unused_br = dec_br & branch_take_i;
endmodule : ics_sequencer

// ==== logic/ics_state_divider.sv ====
// Purpose: Splits the core clock into four states per machine cycle.
// Assumes: Speed mode changes only take effect at a cycle boundary.
// Notes: Emits one-cycle pulses on the last clock of each state and of each cycle.
`timescale 1ns/1ps
module ics_state_divider (
  input wire logic clock_i, // Core clock
  input wire logic srst_i, // Sync reset, active high
  input wire logic [1:0] speed_i, // Requested speed mode
  output logic state_adv_o, // Pulse: next state begins
  output logic cycle_end_o, // Pulse: last clock of machine cycle
  output logic [1:0] slot_o // Current state, 0 = first
);
  logic [10:0] len_q;
  logic [10:0] cnt_q;
  logic [10:0] quarter;

  function automatic logic [10:0] cyc_len(input logic [1:0] sp);
    unique case (sp)
      ics_pkg::ICS_SPEED_SLOW1: cyc_len = ics_pkg::CLK_PER_CYC_SLOW1;
      ics_pkg::ICS_SPEED_SLOW2: cyc_len = ics_pkg::CLK_PER_CYC_SLOW2;
      default: cyc_len = ics_pkg::CLK_PER_CYC_NORMAL;
    endcase
  endfunction : cyc_len

  assign quarter = {2'b00, len_q[10:2]};
  assign cycle_end_o = (cnt_q == len_q - 11'h001);

  // Cycle length latched at each boundary so a cycle never changes length midway
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      len_q <= ics_pkg::CLK_PER_CYC_NORMAL;
      cnt_q <= 11'h000;
    end else if (cycle_end_o) begin
      len_q <= cyc_len(speed_i);
      cnt_q <= 11'h000;
    end else begin
      cnt_q <= cnt_q + 11'h001;
    end
  end

  logic [1:0] slot_q;
  logic [10:0] in_slot_q;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      slot_q <= 2'b00;
      in_slot_q <= 11'h000;
    end else if (cycle_end_o) begin
      slot_q <= 2'b00;
      in_slot_q <= 11'h000;
    end else if (in_slot_q == quarter - 11'h001) begin
      slot_q <= slot_q + 2'b01;
      in_slot_q <= 11'h000;
    end else begin
      in_slot_q <= in_slot_q + 11'h001;
    end
  end
  assign slot_o = slot_q;
  assign state_adv_o = cycle_end_o || (in_slot_q == quarter - 11'h001);
endmodule : ics_state_divider
